// file: hw/twecp_pkg.sv
package twecp_pkg;

   // ----------------------------------------------------------------------
   // Array shape and frame layout
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int WORDS = 64;
   localparam int FRAME_SHORT = 9;
   localparam int FRAME_LONG = 25;
   localparam logic [DATA_W-1:0] WORD_ERASED = 16'hffff;

   localparam logic [1:0] OP_SPECIAL = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [1:0] SPC_DISABLE = 2'h0;
   localparam logic [1:0] SPC_WRITE_ALL = 2'h1;
   localparam logic [1:0] SPC_ERASE_ALL = 2'h2;
   localparam logic [1:0] SPC_ENABLE = 2'h3;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int SYS_CLK_NS = 25;
   localparam int SELECT_LOW_MIN_NS = 250;
   localparam int SELECT_LOW_CYC = (SELECT_LOW_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SHIFT_HIGH_MIN_NS = 250;
   localparam int SHIFT_HALF_CYC = (SHIFT_HIGH_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SELF_TIMED_CYCLE_MS = 10;
   localparam int SELF_TIMED_CYC = SELF_TIMED_CYCLE_MS * 1000000 / SYS_CLK_NS;

   typedef enum logic [2:0] {
      INS_READ = 3'h0,
      INS_WRITE = 3'h1,
      INS_ERASE = 3'h2,
      INS_ENABLE = 3'h3,
      INS_DISABLE = 3'h4,
      INS_ERASE_ALL = 3'h5,
      INS_WRITE_ALL = 3'h6
   } twecp_instr_t;

   function automatic twecp_instr_t twecp_decode(input logic [7:0] opad);
      twecp_instr_t ins;
      ins = INS_DISABLE;
      case (opad[7:6])
         OP_READ: ins = INS_READ;
         OP_WRITE: ins = INS_WRITE;
         OP_ERASE: ins = INS_ERASE;
         default: begin
            case (opad[5:4])
               SPC_ENABLE: ins = INS_ENABLE;
               SPC_ERASE_ALL: ins = INS_ERASE_ALL;
               SPC_WRITE_ALL: ins = INS_WRITE_ALL;
               default: ins = INS_DISABLE;
            endcase
         end
      endcase
      return ins;
   endfunction

   function automatic logic twecp_has_data(input twecp_instr_t ins);
      return (ins == INS_WRITE) || (ins == INS_WRITE_ALL);
   endfunction

endpackage

// file: hw/twecp_link_if.sv
`timescale 1ns/1ps
interface twecp_link_if;
   logic select_line;
   logic shift_clock;
   logic serial_in_pin;
   logic serial_out_data;
   logic serial_out_oe;
   logic serial_out_pin;

   // The released output line is held high, as a board pull-up would.
   assign serial_out_pin = serial_out_oe ? serial_out_data : 1'b1;

   modport dev(
      input select_line,
      input shift_clock,
      input serial_in_pin,
      output serial_out_data,
      output serial_out_oe
   );

   modport host(
      output select_line,
      output shift_clock,
      output serial_in_pin,
      input serial_out_pin
   );
endinterface

// file: hw/twecp_device.sv
`timescale 1ns/1ps
// What this block does
// [RL1] Frame: select rise, start one, opcode, address
// [RL2] Read data changes on shift clock rises
// [RL3] Read outputs dummy zero, then 16 bits
// [RL4] Power-up leaves programming disabled
// [RL5] Host enables before any erase or write
// [RL6] Enable persists until disable or power loss
// [RL7] Word erase sets ones, starts after address
// [RL8] Word write starts after last data bit
// [RL9] Select low 250 ns, then status shown
// [RL10] Status zero while busy, one when done
// [RL11] No status if select rises after cycle
// [RL12] Erase-all sets whole array to ones
// [RL13] Write-all programs every word with data
// [RL14] Disable blocks all erase and write
// [RL15] Read works whether enabled or disabled
// [RL16] Host gives nine clocks for erase, enable, disable and erase-all
// [RL17] Opcodes: read 10, write 01, erase 11
// [RL18] Opcode 00: top address bits pick command
// [RL19] Select low releases the serial output
// [RL20] Sample on rises; select fall discards frame
// [RL21] Busy device ignores all but status polling
module twecp_device #(
   parameter int PROG_CYCLES = twecp_pkg::SELF_TIMED_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   twecp_link_if.dev link,
   output logic prog_enabled,
   output logic prog_busy
);

   localparam int DW = twecp_pkg::DATA_W;
   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam int OPAD_W = 2 + twecp_pkg::ADDR_W;
   localparam logic [4:0] HDR_LAST = 5'(OPAD_W - 1);
   localparam logic [4:0] DATA_LAST = 5'(OPAD_W + DW - 1);
   localparam logic [4:0] RD_LOAD = 5'(OPAD_W);
   localparam logic [4:0] CNT_MAX = 5'h1f;
   localparam logic [3:0] LOW_MIN = 4'(twecp_pkg::SELECT_LOW_CYC);
   localparam logic [TW-1:0] TIMER_LOAD = TW'(PROG_CYCLES - 1);

   typedef struct packed {
      logic started;
      logic [4:0] cnt;
      logic [OPAD_W-1:0] opad;
      logic [DW-1:0] data;
      logic req;
      logic rd_act;
      logic rd_bit;
      logic [DW-1:0] rd_sh;
   } twecp_link_t;

   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic req_m;
      logic req_s;
      logic req_d;
      logic act_m;
      logic act_s;
      logic bit_m;
      logic bit_s;
      logic enabled;
      logic busy;
      logic [TW-1:0] timer;
      twecp_pkg::twecp_instr_t pend;
      logic [twecp_pkg::ADDR_W-1:0] addr;
      logic [DW-1:0] wdata;
      logic [3:0] low_cnt;
      logic status_on;
      logic [DW-1:0] hold;
      logic do_out;
      logic do_oe;
   } twecp_core_t;

   twecp_link_t l;
   twecp_link_t next_l;
   twecp_core_t c;
   twecp_core_t next_c;
   twecp_pkg::twecp_instr_t link_ins;
   twecp_pkg::twecp_instr_t core_ins;
   logic [DW-1:0] mem [twecp_pkg::WORDS];

   // ----------------------------------------------------------------------
   // Link side, clocked by the shift clock
   // ----------------------------------------------------------------------
   // The word to be read is taken from the core's hold register one shift
   // clock after the address is complete. The core fills it within four
   // system clocks, so the shift clock period must exceed that; a handshake
   // would cost several shift clocks of latency the protocol does not allow.
   always_comb begin
      next_l = l;
      link_ins = twecp_pkg::twecp_decode({l.opad[OPAD_W-2:0], link.serial_in_pin});
      if (!l.started) begin
         if (link.serial_in_pin) begin
            next_l.started = 1'b1; // RL1
         end
      end else if (!l.req) begin
         next_l.cnt = l.cnt + 5'h01;
         next_l.data = {l.data[DW-2:0], link.serial_in_pin};
         if (l.cnt <= HDR_LAST) begin
            next_l.opad = {l.opad[OPAD_W-2:0], link.serial_in_pin}; // RL1
         end
         if (l.cnt == HDR_LAST && !twecp_pkg::twecp_has_data(link_ins)) begin
            next_l.req = 1'b1; // RL7
            if (link_ins == twecp_pkg::INS_READ) begin
               next_l.rd_act = 1'b1;
               next_l.rd_bit = 1'b0; // RL3
            end
         end
         if (l.cnt == DATA_LAST) begin
            next_l.req = 1'b1; // RL8
         end
      end else if (l.rd_act) begin
         if (l.cnt != CNT_MAX) begin
            next_l.cnt = l.cnt + 5'h01;
         end
         if (l.cnt == RD_LOAD) begin
            next_l.rd_bit = c.hold[DW-1]; // RL3
            next_l.rd_sh = {c.hold[DW-2:0], 1'b0};
         end else begin
            next_l.rd_bit = l.rd_sh[DW-1]; // RL2
            next_l.rd_sh = {l.rd_sh[DW-2:0], 1'b0};
         end
      end
   end

   // Select low clears the whole frame, even with the shift clock stopped.
   always_ff @(posedge link.shift_clock or negedge link.select_line) begin
      if (!link.select_line) begin
         l <= '0; // RL20
      end else begin
         l <= next_l; // RL20
      end
   end

   // ----------------------------------------------------------------------
   // Core side, clocked by the system clock
   // ----------------------------------------------------------------------
   // The opcode, address and data fields are held steady by the link for as
   // long as its request stands, so they are read once the request is seen.
   always_comb begin
      next_c = c;
      core_ins = twecp_pkg::twecp_decode(l.opad); // RL17 RL18
      next_c.cs_m = link.select_line;
      next_c.cs_s = c.cs_m;
      next_c.cs_d = c.cs_s;
      next_c.req_m = l.req;
      next_c.req_s = c.req_m;
      next_c.req_d = c.req_s;
      next_c.act_m = l.rd_act;
      next_c.act_s = c.act_m;
      next_c.bit_m = l.rd_bit;
      next_c.bit_s = c.bit_m;

      if (c.req_s && !c.req_d && !c.busy) begin // RL21
         case (core_ins)
            twecp_pkg::INS_READ: begin
               next_c.hold = mem[l.opad[twecp_pkg::ADDR_W-1:0]]; // RL15
            end
            twecp_pkg::INS_ENABLE: begin
               next_c.enabled = 1'b1; // RL6
            end
            twecp_pkg::INS_DISABLE: begin
               next_c.enabled = 1'b0; // RL14
            end
            default: begin
               if (c.enabled) begin // RL5 RL14
                  next_c.busy = 1'b1;
                  next_c.timer = TIMER_LOAD;
                  next_c.pend = core_ins;
                  next_c.addr = l.opad[twecp_pkg::ADDR_W-1:0];
                  next_c.wdata = l.data;
               end
            end
         endcase
      end else if (c.busy) begin
         if (c.timer == '0) begin
            next_c.busy = 1'b0;
         end else begin
            next_c.timer = c.timer - TW'(1);
         end
      end

      if (!c.cs_s) begin
         next_c.status_on = 1'b0;
         if (c.low_cnt != LOW_MIN) begin
            next_c.low_cnt = c.low_cnt + 4'h1;
         end
      end else if (!c.cs_d) begin
         next_c.low_cnt = 4'h0;
         next_c.status_on = c.busy && (c.low_cnt == LOW_MIN); // RL9 RL11
      end

      next_c.do_oe = c.cs_s && (next_c.status_on || c.act_s); // RL19
      next_c.do_out = next_c.status_on ? !c.busy : c.bit_s; // RL10
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         c <= '0; // RL4
      end else begin
         c <= next_c;
      end
   end

   // The array is nonvolatile: reset leaves it alone. Contents change when
   // the self-timed cycle ends, so a cut reset leaves the old data intact.
   always_ff @(posedge sys_clk) begin
      if (!sys_rst && c.busy && c.timer == '0) begin
         case (c.pend)
            twecp_pkg::INS_WRITE: mem[c.addr] <= c.wdata; // RL8
            twecp_pkg::INS_ERASE: mem[c.addr] <= twecp_pkg::WORD_ERASED; // RL7
            twecp_pkg::INS_ERASE_ALL: begin
               for (int i = 0; i < twecp_pkg::WORDS; i++) begin
                  mem[i] <= twecp_pkg::WORD_ERASED; // RL12
               end
            end
            twecp_pkg::INS_WRITE_ALL: begin
               for (int i = 0; i < twecp_pkg::WORDS; i++) begin
                  mem[i] <= c.wdata; // RL13
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign link.serial_out_data = c.do_out;
   assign link.serial_out_oe = c.do_oe;
   assign prog_enabled = c.enabled;
   assign prog_busy = c.busy;

endmodule

// file: hw/twecp_host.sv
`timescale 1ns/1ps
module twecp_host (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire twecp_pkg::twecp_instr_t cmd_instr,
   input wire logic [twecp_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [twecp_pkg::DATA_W-1:0] cmd_wdata,
   output logic rsp_valid,
   output logic [twecp_pkg::DATA_W-1:0] rsp_rdata,
   twecp_link_if.host link
);

   localparam int DW = twecp_pkg::DATA_W;
   localparam int FW = twecp_pkg::FRAME_LONG;
   localparam logic [4:0] HALF_LAST = 5'(twecp_pkg::SHIFT_HALF_CYC - 1);
   localparam logic [4:0] GAP_LAST = 5'(twecp_pkg::SELECT_LOW_CYC);
   localparam logic [4:0] POLL_WAIT = 5'(twecp_pkg::SHIFT_HALF_CYC);
   localparam logic [4:0] EDGES_SHORT = 5'(twecp_pkg::FRAME_SHORT);
   localparam logic [4:0] EDGES_LONG = 5'(twecp_pkg::FRAME_LONG);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP = 2'b10,
      ST_POLL = 2'b11
   } twecp_hstate_t;

   typedef struct packed {
      twecp_hstate_t state;
      logic [FW-1:0] tx;
      logic [4:0] last;
      logic [4:0] edges;
      logic [4:0] half;
      logic clk_line;
      logic cs;
      logic data_line;
      logic is_read;
      logic is_prog;
      logic [DW-1:0] rx;
      logic do_m;
      logic do_s;
      logic rdy;
      logic rv;
      logic [DW-1:0] rdata;
   } twecp_host_t;

   twecp_host_t h;
   twecp_host_t next_h;

   function automatic logic [7:0] twecp_host_opad(input twecp_pkg::twecp_instr_t ins,
                                                  input logic [5:0] addr);
      case (ins)
         twecp_pkg::INS_READ: return {twecp_pkg::OP_READ, addr}; // RL17
         twecp_pkg::INS_WRITE: return {twecp_pkg::OP_WRITE, addr};
         twecp_pkg::INS_ERASE: return {twecp_pkg::OP_ERASE, addr};
         twecp_pkg::INS_ENABLE: // RL18
            return {twecp_pkg::OP_SPECIAL, twecp_pkg::SPC_ENABLE, 4'h0};
         twecp_pkg::INS_ERASE_ALL: return {twecp_pkg::OP_SPECIAL, twecp_pkg::SPC_ERASE_ALL, 4'h0};
         twecp_pkg::INS_WRITE_ALL: return {twecp_pkg::OP_SPECIAL, twecp_pkg::SPC_WRITE_ALL, 4'h0};
         default: return {twecp_pkg::OP_SPECIAL, twecp_pkg::SPC_DISABLE, 4'h0};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   // Every frame, short or long, ends with select held low for a full
   // minimum low time, so back-to-back commands never violate it.
   always_comb begin
      next_h = h;
      next_h.do_m = link.serial_out_pin;
      next_h.do_s = h.do_m;
      next_h.rv = 1'b0;
      case (h.state)
         ST_IDLE: begin
            next_h.rdy = 1'b1;
            if (cmd_valid && h.rdy) begin
               next_h.rdy = 1'b0;
               next_h.tx = {1'b1, twecp_host_opad(cmd_instr, cmd_addr), // RL1
                            (cmd_instr == twecp_pkg::INS_READ) ? 16'h0000 : cmd_wdata};
               next_h.is_read = (cmd_instr == twecp_pkg::INS_READ);
               next_h.is_prog = cmd_instr inside {twecp_pkg::INS_WRITE, twecp_pkg::INS_ERASE,
                  twecp_pkg::INS_ERASE_ALL, twecp_pkg::INS_WRITE_ALL};
               next_h.last = (twecp_pkg::twecp_has_data(cmd_instr) || next_h.is_read) ?
                  EDGES_LONG : EDGES_SHORT; // RL16
               next_h.edges = 5'h00;
               next_h.half = 5'h00;
               next_h.cs = 1'b1;
               next_h.data_line = 1'b1;
               next_h.state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            next_h.half = h.half + 5'h01;
            if (h.half == HALF_LAST) begin
               next_h.half = 5'h00;
               if (!h.clk_line) begin
                  next_h.clk_line = 1'b1;
                  next_h.edges = h.edges + 5'h01;
               end else begin
                  next_h.clk_line = 1'b0;
                  if (h.is_read && h.edges > EDGES_SHORT) begin
                     next_h.rx = {h.rx[DW-2:0], h.do_s}; // RL3
                  end
                  if (h.edges == h.last) begin
                     next_h.cs = 1'b0;
                     next_h.data_line = 1'b0;
                     next_h.state = ST_GAP;
                  end else begin
                     next_h.tx = {h.tx[FW-2:0], 1'b0};
                     next_h.data_line = h.tx[FW-2];
                  end
               end
            end
         end
         ST_GAP: begin
            next_h.half = h.half + 5'h01;
            if (h.half == GAP_LAST) begin // RL9
               next_h.half = 5'h00;
               if (h.is_prog) begin
                  next_h.cs = 1'b1;
                  next_h.state = ST_POLL;
               end else begin
                  next_h.rv = 1'b1;
                  next_h.rdata = h.rx;
                  next_h.state = ST_IDLE;
               end
            end
         end
         ST_POLL: begin
            if (h.half != POLL_WAIT) begin
               next_h.half = h.half + 5'h01;
            end else if (h.do_s) begin // RL10
               next_h.cs = 1'b0;
               next_h.is_prog = 1'b0;
               next_h.half = 5'h00;
               next_h.state = ST_GAP;
            end
         end
         default: begin
            next_h.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         h <= '0;
      end else begin
         h <= next_h;
      end
   end

   assign cmd_ready = h.rdy;
   assign rsp_valid = h.rv;
   assign rsp_rdata = h.rdata;
   assign link.select_line = h.cs;
   assign link.shift_clock = h.clk_line;
   assign link.serial_in_pin = h.data_line;

endmodule

// file: verification/twecp_props.sv
`timescale 1ns/1ps
module twecp_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic select_line,
   input wire logic shift_clock,
   input wire logic serial_in_pin,
   input wire logic serial_out_data,
   input wire logic serial_out_oe,
   input wire logic serial_out_pin
);
   // ----------------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------------
   logic [4:0] rise_cnt;
   logic [2:0] head_bits;
   logic [3:0] since_rise;
   logic is_read;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // The shift clock is a flop of the host, so sampling it on sys_clk loses no edge.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !select_line) begin
         rise_cnt <= 5'h00;
         head_bits <= 3'h0;
      end else if ($rose(shift_clock)) begin
         if (rise_cnt != 5'h1f) begin
            rise_cnt <= rise_cnt + 5'h01;
         end
         if (rise_cnt < 5'h03) begin
            head_bits <= {head_bits[1:0], serial_in_pin};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || $rose(shift_clock)) begin
         since_rise <= 4'h0;
      end else if (since_rise != 4'hf) begin
         since_rise <= since_rise + 4'h1;
      end
   end

   assign is_read = (rise_cnt >= 5'h03) && (head_bits == 3'h6);

   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   sequence s_gap_held;
      !select_line [*8] ##1 !select_line ##1 !select_line;
   endsequence

   sequence s_setup_quiet;
      !shift_clock [*8];
   endsequence

   a_start_bit_one: assert property (($rose(shift_clock) && select_line
         && rise_cnt == 5'h00) |-> serial_in_pin)
      else $error("first bit of a frame was not one");
   a_select_setup: assert property ($rose(select_line) |-> s_setup_quiet)
      else $error("shift clock rose too soon after select");
   a_frame_length: assert property ($fell(select_line)
         |-> (rise_cnt == 5'h00 || rise_cnt == 5'h09 || rise_cnt == 5'h19))
      else $error("frame ended with a wrong count of clocks");
   a_select_gap: assert property ($fell(select_line) |-> s_gap_held)
      else $error("select low time too short");
   a_output_release: assert property ($fell(select_line) |-> ##[1:4] !serial_out_oe)
      else $error("serial output not released after select fell");
   a_data_on_rise: assert property (($changed(serial_out_data) && serial_out_oe
         && $past(serial_out_oe) && is_read && select_line) |-> since_rise < 4'h6)
      else $error("read data changed away from a shift clock rise");
   a_dummy_zero: assert property (($rose(serial_out_oe) && is_read) |-> !serial_out_data)
      else $error("read did not begin with a zero bit");
   a_quiet_on_cmd: assert property ((select_line && rise_cnt != 5'h00 && !is_read)
         |-> !serial_out_oe)
      else $error("device drove the output during a non-read frame");
   a_ready_holds: assert property ((select_line && rise_cnt == 5'h00 && serial_out_oe
         && serial_out_pin) |=> (!select_line || serial_out_pin))
      else $error("ready status fell back to busy");
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic sys_clk;
   logic sys_rst;
   logic cmd_valid;
   logic cmd_ready;
   twecp_pkg::twecp_instr_t cmd_instr;
   logic [5:0] cmd_addr;
   logic [15:0] cmd_wdata;
   logic rsp_valid;
   logic [15:0] rsp_rdata;
   logic prog_enabled;
   logic prog_busy;
   logic [15:0] rd;
   logic busy;
   int err_count;
   int checked;

   twecp_link_if link_bus();

   // A short self-timed cycle keeps the run small; polling still sees busy.
   twecp_device #(.PROG_CYCLES(200)) twecp_device_inst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .link(link_bus),
      .prog_enabled(prog_enabled),
      .prog_busy(prog_busy)
   );

   twecp_host twecp_host_inst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready),
      .cmd_instr(cmd_instr),
      .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata),
      .link(link_bus)
   );

   twecp_props props_inst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .select_line(link_bus.select_line),
      .shift_clock(link_bus.shift_clock),
      .serial_in_pin(link_bus.serial_in_pin),
      .serial_out_data(link_bus.serial_out_data),
      .serial_out_oe(link_bus.serial_out_oe),
      .serial_out_pin(link_bus.serial_out_pin)
   );

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // Outputs are looked at on the falling edge, where the flops have settled.
   task automatic run(input twecp_pkg::twecp_instr_t ins, input logic [5:0] addr,
                      input logic [15:0] wd);
      int n;
      busy = 1'b0;
      for (n = 0; n < 100; n++) begin
         @(negedge sys_clk);
         if (cmd_ready === 1'b1) break;
      end
      if (n >= 100) begin
         err_count++;
         wrap_up();
      end
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_instr <= ins;
      cmd_addr <= addr;
      cmd_wdata <= wd;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 5000; n++) begin
         @(negedge sys_clk);
         if (prog_busy === 1'b1) busy = 1'b1;
         if (rsp_valid === 1'b1) break;
      end
      if (n >= 5000) begin
         err_count++;
         wrap_up();
      end
      rd = rsp_rdata;
   endtask

   task automatic rd_chk(input logic [5:0] addr, input logic [15:0] exp);
      run(twecp_pkg::INS_READ, addr, 16'h0000);
      check("read word", rd, exp);
   endtask

   task automatic busy_chk(input logic exp);
      check("busy seen", {15'h0000, busy}, {15'h0000, exp});
   endtask

   // ----------------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_instr = twecp_pkg::INS_READ;
      cmd_addr = 6'h00;
      cmd_wdata = 16'h0000;
      err_count = 0;
      checked = 0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      check("enabled", {15'h0000, prog_enabled}, 16'h0000);
      run(twecp_pkg::INS_WRITE, 6'h05, 16'h1234);
      busy_chk(1'b0);
      run(twecp_pkg::INS_ENABLE, 6'h00, 16'h0000);
      check("enabled", {15'h0000, prog_enabled}, 16'h0001);
      run(twecp_pkg::INS_ERASE_ALL, 6'h00, 16'h0000);
      busy_chk(1'b1);
      rd_chk(6'h05, twecp_pkg::WORD_ERASED);
      rd_chk(6'h3f, twecp_pkg::WORD_ERASED);
      run(twecp_pkg::INS_WRITE, 6'h05, 16'ha5c3);
      busy_chk(1'b1);
      run(twecp_pkg::INS_WRITE, 6'h3f, 16'h0001);
      rd_chk(6'h05, 16'ha5c3);
      rd_chk(6'h3f, 16'h0001);
      check("enabled", {15'h0000, prog_enabled}, 16'h0001);
      run(twecp_pkg::INS_ERASE, 6'h05, 16'h0000);
      busy_chk(1'b1);
      rd_chk(6'h05, twecp_pkg::WORD_ERASED);
      rd_chk(6'h3f, 16'h0001);
      run(twecp_pkg::INS_WRITE_ALL, 6'h00, 16'h3c3c);
      busy_chk(1'b1);
      for (int a = 0; a < twecp_pkg::WORDS; a += 31) begin
         rd_chk(6'(a), 16'h3c3c);
      end
      run(twecp_pkg::INS_DISABLE, 6'h00, 16'h0000);
      check("enabled", {15'h0000, prog_enabled}, 16'h0000);
      run(twecp_pkg::INS_WRITE, 6'h00, 16'h0000);
      busy_chk(1'b0);
      run(twecp_pkg::INS_ERASE_ALL, 6'h00, 16'h0000);
      busy_chk(1'b0);
      rd_chk(6'h00, 16'h3c3c);
      wrap_up();
   end
endmodule
